// file: bench/tb_top.sv
// self-checking bench of the multiply/divide unit: orderings, results, flags, interrupt
// assumes the default latencies and the register map of mdv_pkg; drives the port directly
module tb_top
  import mdv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WDOG_CYC = 4000;

  logic              SYS_CLK;
  logic              SRST;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA;
  logic              WR;
  logic              RD;
  logic [DATA_W-1:0] RDATA;
  logic              IRQ;
  logic              BUSY;
  int                miscompares = 0;
  int                tests_run = 0;
  logic [7:0]        exp_q[$];
  string             nm_q[$];
  int                lat_q[$];
  logic              rd_seen = 1'b0;
  int                bcnt = 0;
  logic [31:0]       rng = 32'h92ab;
  logic              ovf_f = 1'b0;
  logic [1:0]        mask = 2'h0;

  mdv_unit dut (
    .SYS_CLK (SYS_CLK),
    .SRST    (SRST),
    .ADDR    (ADDR),
    .WDATA   (WDATA),
    .WR      (WR),
    .RD      (RD),
    .RDATA   (RDATA),
    .IRQ     (IRQ),
    .BUSY    (BUSY)
  );

  initial
  begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    tests_run++;
    if (g != e)
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // strobes are left up between calls so back-to-back cycles need no gap
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    RD    <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    ADDR <= a;
    WR   <= 1'b0;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
  endtask

  task automatic idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge SYS_CLK);
  endtask

  // read data and busy runs are judged here; an unexpected busy run meets an empty note queue
  always @(posedge SYS_CLK)
  begin
    if (rd_seen)
      chk_val(nm_q.pop_front(), exp_q.pop_front(), RDATA);
    rd_seen <= RD;
    if (BUSY === 1'b1)
      bcnt++;
    else if (bcnt != 0)
    begin
      chk_cnt("busy cycles", lat_q.size() ? lat_q.pop_front() : 0, bcnt);
      bcnt = 0;
    end
  end

  // k: 0 div32, 1 div16, 2 multiply; bad touches data registers while busy
  task automatic run_op(input int k, input logic [31:0] n, input logic [15:0] d, input bit bad);
    logic [31:0] q;
    logic [15:0] r;
    logic        ov;
    int          lat;
    lat = (k == 0) ? 17 : (k == 1) ? 9 : 11;
    if (k == 1)
      n = {16'h0, n[15:0]};
    q  = (k == 2) ? n[15:0] * d : (d == 16'h0) ? 32'hffffffff : n / d;
    r  = (d == 16'h0) ? n[15:0] : n % d;
    ov = (k == 2) ? (q > 32'hffff) : (d == 16'h0);
    wr(OFS_IRQ_MASK, {6'h0, mask});
    wr(4'h0, n[7:0]);
    if (k == 2)
    begin
      wr(4'h4, d[7:0]);
      rd(4'hc, 8'h00, "unmapped");
      wr(4'h1, n[15:8]);
    end
    else
    begin
      wr(4'h1, n[15:8]);
      if (k == 0)
      begin
        wr(4'h2, n[23:16]);
        wr(OFS_STATUS, 8'hff);
        wr(4'h3, n[31:24]);
      end
      wr(4'h4, d[7:0]);
    end
    lat_q.push_back(lat);
    wr(4'h5, d[15:8]);
    if (bad)
    begin
      rd(4'h4, d[7:0], "stale byte");
      wr(4'h4, ~d[7:0]);
      rd(OFS_STATUS, {1'b1, ovf_f, 6'h0}, "status busy");
      idle(lat - 2);
    end
    else
      idle(lat + 1);
    ovf_f = ov;
    chk_val("irq", {7'h0, |({bad, 1'b1} & mask)}, {7'h0, IRQ});
    rd(OFS_STATUS, {bad, ov, 6'h0}, "status");
    idle(1);
    rd(OFS_STATUS, {1'b0, ov, 6'h0}, "status again");
    rd(OFS_IRQ_STAT, {6'h0, bad, 1'b1}, "irq status");
    wr(OFS_IRQ_STAT, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 1)
        rd(OFS_IRQ_MASK, {6'h0, mask}, "mask");
      if (k == 0 || (k == 1 && (i < 2 || i > 3)) || (k == 2 && i < 4))
        rd(i[3:0], i < 4 ? q[8*i +: 8] : r[8*(i-4) +: 8], "result");
    end
    // a multiply leaves byte 4 alone, so a dropped busy write shows here
    if (bad && k == 2)
      rd(4'h4, d[7:0], "kept byte");
    idle(1);
    chk_val("irq cleared", 8'h00, {7'h0, IRQ});
  endtask

  initial
  begin
    logic [31:0] n;
    logic [15:0] d;
    logic [3:0]  seq [2][4];
    logic [7:0]  v [4];
    SRST  = 1'b1;
    ADDR  = 4'h0;
    WDATA = 8'h00;
    WR    = 1'b0;
    RD    = 1'b0;
    seq   = '{'{4'h0, 4'h1, 4'h2, 4'h5}, '{4'h4, 4'h0, 4'h1, 4'h5}};
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    chk_val("busy reset", 8'h00, {7'h0, BUSY});
    rd(OFS_STATUS, 8'h00, "status reset");
    rd(OFS_IRQ_MASK, 8'h00, "mask reset");
    rd(OFS_IRQ_STAT, 8'h00, "irq status reset");
    rd(4'hd, 8'h00, "unmapped");
    for (int t = 0; t < 12; t++)
    begin
      rng  = xs(rng);
      n    = rng;
      rng  = xs(rng);
      d    = rng[15:0];
      mask = t[1:0];
      if (t == 3 || t == 4)
        d = 16'h0000;
      if (t == 5)
      begin
        n = {24'h0, rng[23:16]};
        d = 16'h00ff;
      end
      if (t == 8)
      begin
        n = 32'h0000ffff;
        d = 16'hffff;
      end
      run_op(t % 3, n, d, t == 2 || t == 6);
    end
    // orderings that match no pattern: nothing may start and the bytes stay as written
    for (int j = 0; j < 2; j++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rng  = xs(rng);
        v[i] = rng[7:0];
        wr(seq[j][i], v[i]);
      end
      idle(20);
      for (int i = 0; i < 4; i++)
        rd(seq[j][i], v[i], "kept operand");
    end
    idle(4);
    chk_cnt("pending starts", 0, lat_q.size());
    close_out();
  end

  // generous bound on the whole sequence, some hundreds of cycles in practice
  initial
  begin
    #(WDOG_CYC * 25);
    miscompares++;
    close_out();
  end

endmodule

// file: logic/mdv_calc.sv
// calculation core: latches operands on start, answers after the fixed latency
// assumes start only while not busy; result bytes are valid in the cycle done is high
module mdv_calc
  import mdv_pkg::*;
#(
  parameter int DIV32_LAT = mdv_pkg::DIV32_CYC,
  parameter int DIV16_LAT = mdv_pkg::DIV16_CYC,
  parameter int MUL_LAT   = mdv_pkg::MUL_CYC
)
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire mdv_pkg::mdv_calc_in_t  cin,
  output      mdv_pkg::mdv_calc_out_t cout
);

  // the busy-length helper of the unit counts in CNT_W bits, so 31 is the ceiling
  if (DIV32_LAT < 2 || DIV16_LAT < 2 || MUL_LAT < 2 ||
      DIV32_LAT > 31 || DIV16_LAT > 31 || MUL_LAT > 31)
  begin : g_bad_lat
    $error("mdv_calc latency out of range");
  end

  typedef struct packed {
    logic              busy;
    mdv_op_t           op;
    logic [CNT_W-1:0]  cnt;
    logic [OPND_W-1:0] opnd;
    mdv_calc_out_t     out;
  } mdv_calc_st_t;

  mdv_calc_st_t s;
  mdv_calc_st_t next_s;
  logic [31:0]  dvd;
  logic [15:0]  dvs;
  logic [31:0]  prod;
  logic [31:0]  quot;
  logic [15:0]  rem;

  // 16x16 unsigned multiplier and 32/16 divider
  always_comb
  begin
    dvd  = (s.op == OP_DIV16) ? {16'h0000, s.opnd[15:0]} : s.opnd[31:0];
    dvs  = s.opnd[47:32];
    prod = s.opnd[15:0] * s.opnd[47:32];
    quot = DIVZ_QUOT;
    rem  = dvd[15:0];
    if (dvs != 16'h0000)
    begin
      quot = dvd / {16'h0000, dvs};
      rem  = 16'(dvd % {16'h0000, dvs});
    end
  end

  always_comb
  begin
    next_s          = s;
    next_s.out.done = 1'b0;
    if (cin.start)
    begin
      next_s.busy = 1'b1;
      next_s.op   = cin.op;
      next_s.opnd = cin.opnd;
      case (cin.op)
        OP_DIV32: next_s.cnt = CNT_W'(DIV32_LAT - 2);
        OP_DIV16: next_s.cnt = CNT_W'(DIV16_LAT - 2);
        OP_MUL:   next_s.cnt = CNT_W'(MUL_LAT - 2);
        default:  next_s.cnt = CNT_W'(DIV32_LAT - 2);
      endcase
    end
    else if (s.busy)
    begin
      if (s.cnt == '0)
      begin
        next_s.busy     = 1'b0;
        next_s.out.done = 1'b1;
        if (s.op == OP_MUL)
        begin
          next_s.out.ovf = |prod[31:16];
          next_s.out.we  = WE_MUL;
          next_s.out.res = {16'h0000, prod};
        end
        else
        begin
          next_s.out.ovf = (dvs == 16'h0000);
          next_s.out.we  = (s.op == OP_DIV16) ? WE_DIV16 : WE_DIV32;
          next_s.out.res = {rem, quot};
        end
      end
      else
      begin
        next_s.cnt = s.cnt - CNT_W'(1);
      end
    end
    next_s.out.busy = next_s.busy;
    if (srst)
    begin
      next_s.busy = 1'b0;
      next_s.cnt  = '0;
      next_s.op   = OP_DIV32;
      next_s.out  = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  assign cout = s.out;

  property p_mul_prod;
    @(posedge clk) disable iff (srst)
      cin.start && cin.op == OP_MUL |-> ##11 (cout.done &&
        cout.res[31:0] == $past(cin.opnd[15:0], 11) * $past(cin.opnd[47:32], 11));
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("product wrong or late");

  property p_div16_res;
    @(posedge clk) disable iff (srst)
      cin.start && cin.op == OP_DIV16 && cin.opnd[47:32] != 16'h0000 |-> ##9 (cout.done &&
        cout.res[15:0] == 16'($past(cin.opnd[15:0], 9) / $past(cin.opnd[47:32], 9)));
  endproperty
  a_div16_res: assert property (p_div16_res) else $error("16/16 quotient wrong or late");

endmodule

// file: logic/mdv_pkg.sv
// shared constants and carriers of the multiply/divide unit
// assumes a single system clock; every calculation time is counted in its periods
package mdv_pkg;

  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  localparam int NUM_DATA = 6;
  localparam int OPND_W   = NUM_DATA * DATA_W;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_DATA0    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DATA5    = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;

  // status and interrupt field positions
  localparam int ERR_BIT      = 7;
  localparam int OVF_BIT      = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam int IRQ_W        = 2;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST    = 2'h0;

  // calculation times in system clock periods
  localparam int CLK_PER_SYSTEM_CLOCK_PERIOD = 1;
  localparam int DIV32_SYSTEM_CLOCK_PERIOD   = 17;
  localparam int DIV16_SYSTEM_CLOCK_PERIOD   = 9;
  localparam int MUL_SYSTEM_CLOCK_PERIOD     = 11;
  localparam int DIV32_CYC    = DIV32_SYSTEM_CLOCK_PERIOD * CLK_PER_SYSTEM_CLOCK_PERIOD;
  localparam int DIV16_CYC    = DIV16_SYSTEM_CLOCK_PERIOD * CLK_PER_SYSTEM_CLOCK_PERIOD;
  localparam int MUL_CYC      = MUL_SYSTEM_CLOCK_PERIOD * CLK_PER_SYSTEM_CLOCK_PERIOD;
  localparam int CNT_W        = 5;

  // answer to a division by zero
  localparam logic [31:0] DIVZ_QUOT = 32'hffff_ffff;

  // byte write masks of the result per operation
  localparam logic [NUM_DATA-1:0] WE_DIV32 = 6'h3f;
  localparam logic [NUM_DATA-1:0] WE_DIV16 = 6'h33;
  localparam logic [NUM_DATA-1:0] WE_MUL   = 6'h0f;

  typedef enum logic [1:0] {
    OP_DIV32 = 2'b00,
    OP_DIV16 = 2'b01,
    OP_MUL   = 2'b10
  } mdv_op_t;

  // progress through the operand write orderings
  typedef enum logic [3:0] {
    SQ_IDLE  = 4'b0000,
    SQ_W0    = 4'b0001,
    SQ_W01   = 4'b0010,
    SQ_W012  = 4'b0011,
    SQ_W0123 = 4'b0100,
    SQ_W0123_4 = 4'b0101,
    SQ_W014  = 4'b0110,
    SQ_W04   = 4'b0111,
    SQ_W041  = 4'b1000
  } mdv_seq_t;

  typedef struct packed {
    logic              start;
    mdv_op_t           op;
    logic [OPND_W-1:0] opnd;
  } mdv_calc_in_t;

  typedef struct packed {
    logic                busy;
    logic                done;
    logic                ovf;
    logic [NUM_DATA-1:0] we;
    logic [OPND_W-1:0]   res;
  } mdv_calc_out_t;

endpackage

// file: logic/mdv_unit.sv
// multiply/divide unit: six byte data registers, status, interrupt status and mask
// assumes a simple register port on the system clock, read data one cycle after the strobe
//
// Our own choices: the placing of the registers and strobed register access.
module mdv_unit
  import mdv_pkg::*;
#(
  parameter int DIV32_LAT = mdv_pkg::DIV32_CYC,
  parameter int DIV16_LAT = mdv_pkg::DIV16_CYC,
  parameter int MUL_LAT   = mdv_pkg::MUL_CYC
)
(
  input  wire logic                        SYS_CLK,
  input  wire logic                        SRST,
  input  wire logic [mdv_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [mdv_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output      logic [mdv_pkg::DATA_W-1:0]  RDATA,
  output      logic                        IRQ,
  output      logic                        BUSY
);

  typedef struct packed {
    logic [NUM_DATA-1:0][DATA_W-1:0] data;
    mdv_seq_t                        seq;
    logic                            busy;
    mdv_op_t                         op;
    logic                            err;
    logic                            ovf;
    logic [IRQ_W-1:0]                ist;
    logic [IRQ_W-1:0]                imsk;
    logic                            irq;
    logic [DATA_W-1:0]               rdata;
  } mdv_unit_st_t;

  mdv_unit_st_t  s;
  mdv_unit_st_t  next_s;
  mdv_calc_in_t  calc_in;
  mdv_calc_out_t calc_out;
  logic          acc_data;
  logic          wr_data;
  logic          seq_done;
  mdv_op_t       seq_op;
  logic [2:0]    idx;
  logic          err_evt;
  logic [DATA_W-1:0] status_val;

  assign idx        = ADDR[2:0];
  assign acc_data   = (ADDR <= OFS_DATA5);
  assign wr_data    = WR && acc_data;
  assign status_val = {s.err, s.ovf, 6'h00};
  assign err_evt    = (RD || WR) && acc_data && s.busy;

  // ordering tracker: a byte 0 write while not busy restarts the search, so a stray
  // byte costs only the current attempt, never a later one
  function automatic mdv_seq_t seq_step(input mdv_seq_t cur, input logic [2:0] i);
    mdv_seq_t nxt;
    nxt = SQ_IDLE;
    case (i)
      3'h0: nxt = SQ_W0;
      3'h1: nxt = (cur == SQ_W0) ? SQ_W01 : ((cur == SQ_W04) ? SQ_W041 : SQ_IDLE);
      3'h2: nxt = (cur == SQ_W01) ? SQ_W012 : SQ_IDLE;
      3'h3: nxt = (cur == SQ_W012) ? SQ_W0123 : SQ_IDLE;
      3'h4:
      begin
        case (cur)
          SQ_W0123: nxt = SQ_W0123_4;
          SQ_W01:   nxt = SQ_W014;
          SQ_W0:    nxt = SQ_W04;
          default:  nxt = SQ_IDLE;
        endcase
      end
      default: nxt = SQ_IDLE;
    endcase
    return nxt;
  endfunction

  always_comb
  begin
    seq_done = 1'b0;
    seq_op   = OP_DIV32;
    case (s.seq)
      SQ_W0123_4:
      begin
        seq_done = 1'b1;
        seq_op   = OP_DIV32;
      end
      SQ_W014:
      begin
        seq_done = 1'b1;
        seq_op   = OP_DIV16;
      end
      SQ_W041:
      begin
        seq_done = 1'b1;
        seq_op   = OP_MUL;
      end
      default:
      begin
        seq_done = 1'b0;
        seq_op   = OP_DIV32;
      end
    endcase
  end

  always_comb
  begin
    calc_in.start = wr_data && !s.busy && (ADDR == OFS_DATA5) && seq_done && !SRST;
    calc_in.op    = seq_op;
    calc_in.opnd  = {WDATA, s.data[4], s.data[3], s.data[2], s.data[1], s.data[0]};
  end

  mdv_calc #(
    .DIV32_LAT (DIV32_LAT),
    .DIV16_LAT (DIV16_LAT),
    .MUL_LAT   (MUL_LAT)
  ) u_calc (
    .clk  (SYS_CLK),
    .srst (SRST),
    .cin  (calc_in),
    .cout (calc_out)
  );

  always_comb
  begin
    next_s       = s;
    next_s.rdata = 8'h00;
    // reads answer in the next cycle only; data bytes read as stored, even stale
    if (RD)
    begin
      if (acc_data)
      begin
        next_s.rdata = s.data[idx];
      end
      else if (ADDR == OFS_STATUS)
      begin
        next_s.rdata = status_val;
        if (s.err && !s.busy)
        begin
          next_s.err = 1'b0;
        end
      end
      else if (ADDR == OFS_IRQ_STAT)
      begin
        next_s.rdata = {6'h00, s.ist};
      end
      else if (ADDR == OFS_IRQ_MASK)
      begin
        next_s.rdata = {6'h00, s.imsk};
      end
    end
    if (WR)
    begin
      // a data write while busy is dropped: the operands in flight stay intact
      if (wr_data && !s.busy)
      begin
        next_s.data[idx] = WDATA;
        if (ADDR == OFS_DATA5)
        begin
          next_s.seq = SQ_IDLE;
        end
        else
        begin
          next_s.seq = seq_step(s.seq, idx);
        end
      end
      else if (ADDR == OFS_IRQ_STAT)
      begin
        next_s.ist = s.ist & ~WDATA[IRQ_W-1:0];
      end
      else if (ADDR == OFS_IRQ_MASK)
      begin
        next_s.imsk = WDATA[IRQ_W-1:0];
      end
    end
    if (calc_in.start)
    begin
      next_s.busy = 1'b1;
      next_s.op   = seq_op;
    end
    if (calc_out.done)
    begin
      for (int i = 0; i < NUM_DATA; i++)
      begin
        if (calc_out.we[i])
        begin
          next_s.data[i] = calc_out.res[i*DATA_W +: DATA_W];
        end
      end
      next_s.ovf = calc_out.ovf;
      next_s.busy = 1'b0;
      next_s.ist[IRQ_DONE_BIT] = 1'b1;
    end
    // events placed after the clear so a set in the same cycle wins
    if (err_evt)
    begin
      next_s.err = 1'b1;
      next_s.ist[IRQ_ERR_BIT] = 1'b1;
    end
    next_s.irq = |(next_s.ist & next_s.imsk);
    if (SRST)
    begin
      next_s.seq   = SQ_IDLE;
      next_s.busy  = 1'b0;
      next_s.op    = OP_DIV32;
      next_s.err   = STATUS_RST[ERR_BIT];
      next_s.ovf   = STATUS_RST[OVF_BIT];
      next_s.ist   = IRQ_RST;
      next_s.imsk  = IRQ_RST;
      next_s.irq   = 1'b0;
      next_s.rdata = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    s <= next_s;
  end

  assign RDATA = s.rdata;
  assign IRQ   = s.irq;
  assign BUSY  = s.busy;

  // helper: cycles the unit has been busy, for the latency check
  logic [CNT_W-1:0] busy_len;
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || !s.busy)
    begin
      busy_len <= '0;
    end
    else
    begin
      busy_len <= busy_len + CNT_W'(1);
    end
  end

  int lat_div32;
  int lat_div16;
  int lat_mul;
  assign lat_div32 = DIV32_LAT;
  assign lat_div16 = DIV16_LAT;
  assign lat_mul   = MUL_LAT;

  property p_start;
    @(posedge SYS_CLK) disable iff (SRST)
      WR && ADDR == OFS_DATA5 && !BUSY && seq_done |=> BUSY && s.op == $past(seq_op);
  endproperty
  a_start: assert property (p_start) else $error("valid ordering did not start");

  property p_no_start;
    @(posedge SYS_CLK) disable iff (SRST)
      WR && ADDR == OFS_DATA5 && !BUSY && !seq_done |=> !BUSY && s.data[5] == $past(WDATA);
  endproperty
  a_no_start: assert property (p_no_start) else $error("bad ordering started");

  property p_latency;
    @(posedge SYS_CLK) disable iff (SRST)
      $fell(BUSY) |-> int'(busy_len) == ((s.op == OP_MUL) ? lat_mul :
                       ((s.op == OP_DIV16) ? lat_div16 : lat_div32));
  endproperty
  a_latency: assert property (p_latency) else $error("calculation time wrong");

  property p_div32_order;
    @(posedge SYS_CLK) disable iff (SRST)
      wr_data && !BUSY && idx == 3'h4 && s.seq == SQ_W0123 |=> s.seq == SQ_W0123_4;
  endproperty
  a_div32_order: assert property (p_div32_order) else $error("div32 ordering lost");

  property p_div16_order;
    @(posedge SYS_CLK) disable iff (SRST)
      wr_data && !BUSY && idx == 3'h4 && s.seq == SQ_W01 |=> s.seq == SQ_W014;
  endproperty
  a_div16_order: assert property (p_div16_order) else $error("div16 ordering lost");

  property p_mul_order;
    @(posedge SYS_CLK) disable iff (SRST)
      wr_data && !BUSY && idx == 3'h1 && s.seq == SQ_W04 |=> s.seq == SQ_W041;
  endproperty
  a_mul_order: assert property (p_mul_order) else $error("mul ordering lost");

  property p_hold_seq;
    @(posedge SYS_CLK) disable iff (SRST)
      !wr_data |=> $stable(s.seq);
  endproperty
  a_hold_seq: assert property (p_hold_seq) else $error("ordering disturbed");

  property p_err_set;
    @(posedge SYS_CLK) disable iff (SRST)
      (RD || WR) && acc_data && BUSY |=> s.err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_err_clr;
    @(posedge SYS_CLK) disable iff (SRST)
      RD && ADDR == OFS_STATUS && s.err && !BUSY |=> !s.err ##0 RDATA[ERR_BIT];
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error flag not cleared");

  property p_ovf;
    @(posedge SYS_CLK) disable iff (SRST)
      calc_out.done |=> s.ovf == ((s.op == OP_MUL) ? (s.data[3] != 8'h00 ||
        s.data[2] != 8'h00) : $past(calc_out.ovf));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_status_rd;
    @(posedge SYS_CLK) disable iff (SRST)
      RD && ADDR == OFS_STATUS |=> RDATA[5:0] == 6'h00 && RDATA[OVF_BIT] == $past(s.ovf);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_div32_res;
    @(posedge SYS_CLK) disable iff (SRST)
      calc_out.done && s.op == OP_DIV32 |=> {s.data[3], s.data[2], s.data[1], s.data[0]}
        == $past(calc_out.res[31:0]);
  endproperty
  a_div32_res: assert property (p_div32_res) else $error("div32 quotient not stored");

  // a mask write in the completion cycle may legally withdraw the request
  property p_irq;
    @(posedge SYS_CLK) disable iff (SRST)
      calc_out.done && s.imsk[IRQ_DONE_BIT] && !(WR && ADDR == OFS_IRQ_MASK) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output wrong");

  c_div32: cover property (@(posedge SYS_CLK) disable iff (SRST)
    calc_in.start && seq_op == OP_DIV32);
  c_div16: cover property (@(posedge SYS_CLK) disable iff (SRST)
    calc_in.start && seq_op == OP_DIV16);
  c_mul: cover property (@(posedge SYS_CLK) disable iff (SRST)
    calc_in.start && seq_op == OP_MUL);
  c_err: cover property (@(posedge SYS_CLK) disable iff (SRST) err_evt);

endmodule
